// file: flash_seq.sv
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_seq
    import flash_seq_pkg::*;
#(
    parameter int PAGE_PROG_CYCLES  = `PAGE_PROG_TIME_US * `CLK_MHZ,
    parameter int SECTOR_CYCLES     = `SECTOR_ERASE_TIME_US * `CLK_MHZ,
    parameter int HALF_BLOCK_CYCLES = `HALF_BLOCK_ERASE_TIME_US * `CLK_MHZ
) (
    // system clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic ce_i,
    // serial link
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    input  wire logic dual_line_zero_i,
    output logic      dual_line_zero_o,
    output logic      dual_line_zero_oe_b_o,
    input  wire logic dual_line_one_i,
    output logic      dual_line_one_o,
    output logic      dual_line_one_oe_b_o,
    // protection settings
    input  wire logic protect_range_hi_i,
    input  wire logic protect_range_lo_i,
    input  wire logic protect_top_bottom_i,
    // status
    output logic      busy_o,
    output logic      write_latch_flag_o,
    output logic      cont_read_active_o
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // storage and state

    logic [7:0]  mem_q [int'(`ARRAY_BYTES)];
    logic [7:0]  page_buf [int'(`PAGE_BYTES)];

    link_state_t lk_ff;
    link_state_t nxt_lk;
    drive_t      drv_ff;
    drive_t      nxt_drv;
    core_state_t cr_ff;
    core_state_t nxt_cr;
    logic        fresh_ff;

    logic        cs_s;
    logic [4:0]  stat_s;
    logic        busy_s;
    logic [7:0]  status_byte;
    link_st_t    st_e;
    logic [3:0]  cnt_e;
    logic [7:0]  byte_in;
    logic [7:0]  mode_new;
    logic        buf_we;
    logic        mem_we;
    logic [15:0] mem_wa;
    logic [7:0]  mem_wd;
    logic        cs_rise;
    logic        req_prog;
    op_kind_t    req_kind;
    logic [15:0] req_base;
    logic [16:0] req_len;
    logic [21:0] req_time;
    logic [16:0] prot_size;
    logic [16:0] req_hi;
    logic        prot_hit;
    logic        go;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // crossings

    level_sync #(.WIDTH(1)) u_cs_sync (
        .clk_i   (mclk_i),
        .rst_b_i (rst_b_i),
        .en_i    (ce_i),
        .d_i     (~cs_n_i),
        .q_o     (cs_s)
    );

    level_sync #(.WIDTH(5)) u_stat_sync (
        .clk_i   (sclk_i),
        .rst_b_i (rst_b_i),
        .en_i    (1'b1),
        .d_i     ({protect_top_bottom_i, protect_range_hi_i, protect_range_lo_i,
                   cr_ff.write_latch_flag, cr_ff.busy}),
        .q_o     (stat_s)
    );

    assign busy_s      = stat_s[0];
    assign status_byte = {2'h0, stat_s[4], 1'b0, stat_s[3:2], stat_s[1], stat_s[0]};

    ////////////////////////////////////////////////////////////////////////////////////////////
    // link side

    always_ff @(posedge sclk_i or posedge cs_n_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            fresh_ff <= 1'b1;
        else if (cs_n_i)
            fresh_ff <= 1'b1;
        else
            fresh_ff <= 1'b0;
    end

    always_comb
    begin
        nxt_lk   = lk_ff;
        nxt_lk.arm = 1'b0;
        buf_we   = 1'b0;
        byte_in  = {lk_ff.sh[6:0], dual_line_zero_i};
        mode_new = {lk_ff.mode[5:0], dual_line_one_i, dual_line_zero_i};
        st_e     = lk_ff.st;
        cnt_e    = lk_ff.cnt;
        if (fresh_ff)
        begin
            cnt_e       = 4'h0;
            nxt_lk.bcnt = 2'h0;
            if (!lk_ff.cont)
                st_e = L_OPC;
            else if (busy_s)
                st_e = L_IGN;
            else
                st_e = L_DADDR;
        end
        nxt_lk.st  = st_e;
        nxt_lk.sh  = byte_in;
        nxt_lk.cnt = cnt_e + 4'h1;
        unique case (st_e)
            L_OPC:
            begin
                if (cnt_e == `BYTE_LAST)
                begin
                    nxt_lk.cnt = 4'h0;
                    nxt_lk.op  = byte_in;
                    nxt_lk.st  = L_IGN;
                    if (byte_in == `OP_READ_STATUS)
                    begin
                        nxt_lk.st     = L_STAT;
                        nxt_lk.out_sr = status_byte;
                    end
                    else if (!busy_s)
                    begin
                        if (byte_in == `OP_WRITE_EN || byte_in == `OP_WRITE_DIS)
                            nxt_lk.arm = 1'b1;
                        else if (byte_in == `OP_DUAL_READ)
                            nxt_lk.st = L_DADDR;
                        else if (byte_in == `OP_PAGE_PROG)
                        begin
                            nxt_lk.st    = L_SADDR;
                            nxt_lk.valid = '0;
                        end
                        else if (byte_in == `OP_SECTOR_ERASE || byte_in == `OP_HALF_BLOCK)
                            nxt_lk.st = L_SADDR;
                    end
                end
            end
            L_SADDR:
            begin
                nxt_lk.addr = {lk_ff.addr[22:0], dual_line_zero_i};
                if (cnt_e == `BYTE_LAST)
                begin
                    nxt_lk.cnt  = 4'h0;
                    nxt_lk.bcnt = lk_ff.bcnt + 2'h1;
                    if (lk_ff.bcnt == 2'h2)
                    begin
                        if (lk_ff.op == `OP_PAGE_PROG)
                            nxt_lk.st = L_DATA_IN;
                        else
                        begin
                            nxt_lk.arm = 1'b1;
                            nxt_lk.st  = L_IGN;
                        end
                    end
                end
            end
            L_DATA_IN:
            begin
                if (cnt_e == `BYTE_LAST)
                begin
                    nxt_lk.cnt                     = 4'h0;
                    buf_we                         = 1'b1;
                    nxt_lk.valid[lk_ff.addr[7:0]]  = 1'b1;
                    nxt_lk.addr[7:0]               = lk_ff.addr[7:0] + 8'h01;
                    nxt_lk.arm                     = 1'b1;
                end
            end
            L_DADDR:
            begin
                nxt_lk.addr = {lk_ff.addr[21:0], dual_line_one_i, dual_line_zero_i};
                if (cnt_e == `DADDR_LAST)
                begin
                    nxt_lk.cnt = 4'h0;
                    nxt_lk.st  = L_DMODE;
                end
            end
            L_DMODE:
            begin
                nxt_lk.mode = mode_new;
                if (cnt_e == `PAIR_LAST)
                begin
                    nxt_lk.cont   = (mode_new[5:4] == `CONT_KEEP_CODE);
                    nxt_lk.cnt    = 4'h0;
                    nxt_lk.st     = L_DOUT;
                    nxt_lk.out_sr = mem_q[lk_ff.addr[15:0]];
                    nxt_lk.addr   = lk_ff.addr + 24'h000001;
                end
            end
            L_DOUT:
            begin
                if (cnt_e == `PAIR_LAST)
                begin
                    nxt_lk.cnt    = 4'h0;
                    nxt_lk.out_sr = mem_q[lk_ff.addr[15:0]];
                    nxt_lk.addr   = lk_ff.addr + 24'h000001;
                end
                else
                    nxt_lk.out_sr = {lk_ff.out_sr[5:0], 2'h0};
            end
            L_STAT:
            begin
                if (cnt_e == `BYTE_LAST)
                begin
                    nxt_lk.cnt    = 4'h0;
                    nxt_lk.out_sr = status_byte;
                end
                else
                    nxt_lk.out_sr = {lk_ff.out_sr[6:0], 1'b0};
            end
            L_IGN:
                nxt_lk.cnt = 4'h0;
        endcase
    end

    always_ff @(posedge sclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            lk_ff <= '0;
        else
            lk_ff <= nxt_lk;
    end

    always_ff @(posedge sclk_i)
    begin
        if (buf_we)
            page_buf[lk_ff.addr[7:0]] <= byte_in;
    end

    // pins change on the falling edge, released whenever chip select is high
    always_comb
    begin
        nxt_drv = '{d1: 1'b0, d0: 1'b0, oe1_b: 1'b1, oe0_b: 1'b1};
        if (lk_ff.st == L_DOUT)
            nxt_drv = '{d1: lk_ff.out_sr[7], d0: lk_ff.out_sr[6], oe1_b: 1'b0, oe0_b: 1'b0};
        else if (lk_ff.st == L_STAT)
            nxt_drv = '{d1: lk_ff.out_sr[7], d0: 1'b0, oe1_b: 1'b0, oe0_b: 1'b1};
    end

    always_ff @(negedge sclk_i or posedge cs_n_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            drv_ff <= '{d1: 1'b0, d0: 1'b0, oe1_b: 1'b1, oe0_b: 1'b1};
        else if (cs_n_i)
            drv_ff <= '{d1: 1'b0, d0: 1'b0, oe1_b: 1'b1, oe0_b: 1'b1};
        else
            drv_ff <= nxt_drv;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // core side

    assign cs_rise  = ~cs_s & cr_ff.cs_d;
    assign req_prog = (lk_ff.op == `OP_PAGE_PROG) || (lk_ff.op == `OP_SECTOR_ERASE) ||
                      (lk_ff.op == `OP_HALF_BLOCK);

    always_comb
    begin
        req_kind = K_PP;
        req_base = {lk_ff.addr[15:8], 8'h00};
        req_len  = `PAGE_BYTES;
        req_time = 22'(PAGE_PROG_CYCLES);
        if (lk_ff.op == `OP_SECTOR_ERASE)
        begin
            req_kind = K_SE;
            req_base = {lk_ff.addr[15:12], 12'h000};
            req_len  = `SECTOR_BYTES;
            req_time = 22'(SECTOR_CYCLES);
        end
        else if (lk_ff.op == `OP_HALF_BLOCK)
        begin
            req_kind = K_BE;
            req_base = {lk_ff.addr[15], 15'h0000};
            req_len  = `HALF_BLOCK_BYTES;
            req_time = 22'(HALF_BLOCK_CYCLES);
        end
        unique case ({protect_range_hi_i, protect_range_lo_i})
            2'h0: prot_size = 17'h00000;
            2'h1: prot_size = `PROT_SIZE_1;
            2'h2: prot_size = `PROT_SIZE_2;
            2'h3: prot_size = `PROT_SIZE_3;
        endcase
        req_hi = {1'b0, req_base} + req_len - 17'h00001;
        if (prot_size == 17'h00000)
            prot_hit = 1'b0;
        else if (protect_top_bottom_i)
            prot_hit = {1'b0, req_base} < prot_size;
        else
            prot_hit = req_hi >= (`ARRAY_BYTES - prot_size);
    end

    assign go = ce_i && cs_rise && lk_ff.arm && req_prog && !cr_ff.busy && cr_ff.write_latch_flag &&
                !prot_hit;

    always_comb
    begin
        nxt_cr      = cr_ff;
        nxt_cr.cs_d = cs_s;
        mem_wa      = 16'({1'b0, cr_ff.base} + cr_ff.idx);
        mem_wd      = `ERASED_BYTE;
        mem_we      = 1'b0;
        if (cr_ff.busy)
        begin
            if (cr_ff.idx < cr_ff.len)
            begin
                mem_we     = (cr_ff.kind != K_PP) || lk_ff.valid[cr_ff.idx[7:0]];
                nxt_cr.idx = cr_ff.idx + 17'h00001;
                if (cr_ff.kind == K_PP)
                    mem_wd = mem_q[mem_wa] & page_buf[cr_ff.idx[7:0]];
            end
            if (cr_ff.timer != 22'h000000)
                nxt_cr.timer = cr_ff.timer - 22'h000001;
            else if (cr_ff.idx >= cr_ff.len)
            begin
                nxt_cr.busy = 1'b0;
                nxt_cr.write_latch_flag  = 1'b0;
            end
        end
        else if (cs_rise && lk_ff.arm)
        begin
            if (lk_ff.op == `OP_WRITE_EN)
                nxt_cr.write_latch_flag = 1'b1;
            else if (lk_ff.op == `OP_WRITE_DIS)
                nxt_cr.write_latch_flag = 1'b0;
            else if (go)
            begin
                nxt_cr.busy  = 1'b1;
                nxt_cr.kind  = req_kind;
                nxt_cr.base  = req_base;
                nxt_cr.idx   = 17'h00000;
                nxt_cr.len   = req_len;
                nxt_cr.timer = req_time;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cr_ff <= '{cs_d: 1'b0, busy: 1'b0, write_latch_flag: 1'b0, kind: K_PP, base: 16'h0000,
                       idx: 17'h00000, len: 17'h00000, timer: 22'h000000};
        else if (ce_i)
            cr_ff <= nxt_cr;
    end

    always_ff @(posedge mclk_i)
    begin
        if (ce_i && mem_we)
            mem_q[mem_wa] <= mem_wd;
    end

    assign busy_o             = cr_ff.busy;
    assign write_latch_flag_o = cr_ff.write_latch_flag;
    assign cont_read_active_o = lk_ff.cont;
    assign dual_line_zero_o      = drv_ff.d0;
    assign dual_line_zero_oe_b_o = drv_ff.oe0_b;
    assign dual_line_one_o       = drv_ff.d1;
    assign dual_line_one_oe_b_o  = drv_ff.oe1_b;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // checks

    busy_start_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        go |=> cr_ff.busy)
        else $error("busy not raised after accepted cycle");

    wel_needed_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && $rose(cr_ff.busy)) |-> $past(cr_ff.write_latch_flag))
        else $error("cycle started without write latch");

    wel_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        $fell(cr_ff.busy) |-> !cr_ff.write_latch_flag)
        else $error("write latch still set after cycle");

    protect_skip_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && cs_rise && lk_ff.arm && req_prog && !cr_ff.busy && prot_hit) |=> !cr_ff.busy)
        else $error("protected target started a cycle");

    busy_locked_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && cr_ff.busy && cs_rise) |=> ($stable(cr_ff.kind) && $stable(cr_ff.base)))
        else $error("running cycle disturbed by new instruction");

    mode_pair_a: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        (lk_ff.st == L_DMODE && lk_ff.cnt == `PAIR_LAST && !fresh_ff)
        |=> (lk_ff.cont == (lk_ff.mode[5:4] == `CONT_KEEP_CODE)))
        else $error("continuous mode does not follow mode pair");

    dual_entry_a: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        (lk_ff.st == L_OPC && lk_ff.cnt == `BYTE_LAST && !fresh_ff && !busy_s &&
         {lk_ff.sh[6:0], dual_line_zero_i} == `OP_DUAL_READ) |=> lk_ff.st == L_DADDR)
        else $error("dual read opcode not followed by dual address");

    page_wrap_a: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        (lk_ff.st == L_DATA_IN && lk_ff.cnt == `BYTE_LAST && !fresh_ff)
        |=> (lk_ff.addr[7:0] == $past(lk_ff.addr[7:0]) + 8'h01 && $stable(lk_ff.addr[23:8])))
        else $error("program address left its page");

    arm_boundary_a: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        lk_ff.arm |-> lk_ff.cnt == 4'h0)
        else $error("instruction armed off a byte boundary");

endmodule // flash_seq

// file: flash_seq_params.svh
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// instruction codes
`define OP_WRITE_EN      8'h06
`define OP_WRITE_DIS     8'h04
`define OP_READ_STATUS   8'h05
`define OP_DUAL_READ     8'hBB
`define OP_PAGE_PROG     8'h02
`define OP_SECTOR_ERASE  8'h20
`define OP_HALF_BLOCK    8'h52

// continuous read mode
`define CONT_KEEP_CODE   2'h2

// array geometry
`define PAGE_BYTES       17'h00100
`define SECTOR_BYTES     17'h01000
`define HALF_BLOCK_BYTES 17'h08000
`define ARRAY_BYTES      17'h10000
`define ERASED_BYTE      8'hFF

// protected region sizes per protect_range code
`define PROT_SIZE_1      17'h04000
`define PROT_SIZE_2      17'h08000
`define PROT_SIZE_3      17'h10000

// link shift counts
`define BYTE_LAST        4'h7
`define DADDR_LAST       4'hB
`define PAIR_LAST        4'h3

// timing
`define CLK_MHZ                 25
`define PAGE_PROG_TIME_US       800
`define SECTOR_ERASE_TIME_US    30000
`define HALF_BLOCK_ERASE_TIME_US 120000

`endif

// file: flash_seq_pkg.sv
package flash_seq_pkg;

    typedef enum logic [2:0] {
        L_OPC, L_SADDR, L_DATA_IN, L_DADDR, L_DMODE, L_DOUT, L_STAT, L_IGN
    } link_st_t;

    typedef enum logic [1:0] {K_PP, K_SE, K_BE} op_kind_t;

    typedef struct packed {
        link_st_t     st;
        logic [3:0]   cnt;
        logic [7:0]   sh;
        logic [7:0]   op;
        logic [23:0]  addr;
        logic [1:0]   bcnt;
        logic [7:0]   mode;
        logic         cont;
        logic         arm;
        logic [7:0]   out_sr;
        logic [255:0] valid;
    } link_state_t;

    typedef struct packed {
        logic d1;
        logic d0;
        logic oe1_b;
        logic oe0_b;
    } drive_t;

    typedef struct packed {
        logic        cs_d;
        logic        busy;
        logic        write_latch_flag;
        op_kind_t    kind;
        logic [15:0] base;
        logic [16:0] idx;
        logic [16:0] len;
        logic [21:0] timer;
    } core_state_t;

endpackage

// file: level_sync.sv
`timescale 1ns/1ps

module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             en_i,
    // levels
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_ff <= '0;
            q_ff    <= '0;
        end
        else if (en_i)
        begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;

endmodule // level_sync

// file: spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
    // link outputs
    output logic       sclk_o,
    output logic       cs_n_o,
    output logic [1:0] line_o,
    // link inputs
    input  wire logic [1:0] line_i
);
    logic [1:0] rx;
    logic       off;

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        line_o = 2'h3;
        off = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one clock: lines set while clock is low, sampled on the rise; once released they are no longer set, only inverted while clock is high
    task automatic clk(input logic [1:0] v, input logic rel);
        if (!off)
            line_o = v;
        #3 sclk_o = 1'b1;
        rx = line_i;
        #1;
        off = off | rel;
        if (off)
            line_o = ~line_o;
        #2 sclk_o = 1'b0;
    endtask

    // chip select held low for the whole frame
    task automatic start();
        off = 1'b0;
        #2 cs_n_o = 1'b0;
        #3;
    endtask

    task automatic stop();
        #3 cs_n_o = 1'b1;
        off = 1'b0;
        line_o = ~line_o;
    endtask
endmodule // spi_host_model

// file: tb.sv
`timescale 1ns/1ps

module tb;
    logic        mclk;
    logic        rst_b;
    logic        bp_hi;
    logic        bp_lo;
    logic        bp_tb;
    logic        sclk;
    logic        cs_n;
    logic [1:0]  host_line;
    logic [1:0]  line_in;
    logic [1:0]  dev_d;
    logic [1:0]  dev_oe_b;
    logic        busy;
    logic        write_latch_flag;
    logic        cont;
    logic [15:0] q;
    logic [7:0]  s;
    int          error_cnt;
    int          comparisons;

    always #20 mclk = ~mclk;

    assign line_in[0] = (dev_oe_b[0] === 1'b0) ? dev_d[0] : host_line[0];
    assign line_in[1] = (dev_oe_b[1] === 1'b0) ? dev_d[1] : host_line[1];

    spi_host_model i_host (
        .sclk_o (sclk),
        .cs_n_o (cs_n),
        .line_o (host_line),
        .line_i (line_in)
    );

    flash_seq #(
        .PAGE_PROG_CYCLES  (300),
        .SECTOR_CYCLES     (4100),
        .HALF_BLOCK_CYCLES (33000)
    ) i_dut (
        .mclk_i                (mclk),
        .rst_b_i               (rst_b),
        .ce_i                  (1'b1),
        .sclk_i                (sclk),
        .cs_n_i                (cs_n),
        .dual_line_zero_i      (line_in[0]),
        .dual_line_zero_o      (dev_d[0]),
        .dual_line_zero_oe_b_o (dev_oe_b[0]),
        .dual_line_one_i       (line_in[1]),
        .dual_line_one_o       (dev_d[1]),
        .dual_line_one_oe_b_o  (dev_oe_b[1]),
        .protect_range_hi_i    (bp_hi),
        .protect_range_lo_i    (bp_lo),
        .protect_top_bottom_i  (bp_tb),
        .busy_o                (busy),
        .write_latch_flag_o    (write_latch_flag),
        .cont_read_active_o    (cont)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks and verdict
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t data got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // link access
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = 31; i > 31 - n; i--)
            i_host.clk({1'b1, v[i]}, 1'b0);
    endtask

    task automatic wr(input logic [31:0] v, input int n);
        i_host.start();
        bits(v, n);
        i_host.stop();
        repeat (6) @(negedge mclk);
    endtask

    task automatic prog(input logic [23:0] a, input logic [23:0] d, input int n);
        i_host.start();
        bits({8'h02, a}, 32);
        bits({d, 8'h00}, 8 * n);
        i_host.stop();
        repeat (6) @(negedge mclk);
    endtask

    task automatic stat(output logic [7:0] r);
        i_host.start();
        bits(32'h0500_0000, 8);
        for (int i = 7; i >= 0; i--)
        begin
            i_host.clk(2'h3, 1'b0);
            r[i] = i_host.rx[1];
        end
        i_host.stop();
        repeat (6) @(negedge mclk);
    endtask

    task automatic dread(input logic opc, input logic [23:0] a, input logic [7:0] m,
                         output logic [15:0] r);
        i_host.start();
        if (opc)
            bits(32'hBB00_0000, 8);
        for (int i = 22; i >= 0; i -= 2)
            i_host.clk(a[i+:2], 1'b0);
        for (int i = 6; i >= 0; i -= 2)
            i_host.clk(m[i+:2], i == 0);
        for (int i = 14; i >= 0; i -= 2)
        begin
            i_host.clk(2'h0, 1'b1);
            r[i+:2] = i_host.rx;
        end
        i_host.stop();
        repeat (6) @(negedge mclk);
    endtask

    task automatic idle_chk();
        for (int i = 0; i < 40000 && busy !== 1'b0; i++)
            @(negedge mclk);
        chk_flag(busy, 1'b0);
        chk_flag(write_latch_flag, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // tests
    initial
    begin
        #2000000;
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        {bp_hi, bp_lo, bp_tb} = 3'h0;
        error_cnt = 0;
        comparisons = 0;
        i_host.clk(2'h3, 1'b0);
        i_host.clk(2'h3, 1'b0);
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        chk_flag(busy, 1'b0);
        chk_flag(cont, 1'b0);
        wr(32'hFFFF_0000, 16);
        chk_flag(cont, 1'b0);
        wr(32'h0600_0000, 8);
        chk_flag(write_latch_flag, 1'b1);
        wr(32'h2000_0000, 32);
        chk_flag(busy, 1'b1);
        stat(s);
        chk_data({8'h00, s}, 16'h0003);
        wr(32'h0400_0000, 8);
        stat(s);
        chk_data({8'h00, s}, 16'h0003);
        idle_chk();
        prog(24'h000010, 24'h550000, 1);
        chk_flag(busy, 1'b0);
        wr(32'h0600_0000, 8);
        prog(24'h0000FE, 24'hA53C96, 3);
        chk_flag(busy, 1'b1);
        idle_chk();
        dread(1'b1, 24'h000000, 8'hE5, q);
        chk_data(q, 16'h96FF);
        chk_flag(cont, 1'b1);
        dread(1'b0, 24'h0000FE, 8'h1A, q);
        chk_data(q, 16'hA53C);
        chk_flag(cont, 1'b0);
        dread(1'b1, 24'h000FFE, 8'h20, q);
        chk_data(q, 16'hFFFF);
        chk_flag(cont, 1'b1);
        wr(32'hFFFF_0000, 16);
        chk_flag(cont, 1'b0);
        dread(1'b1, 24'h000010, 8'h00, q);
        chk_data(q, 16'hFFFF);
        wr(32'h0600_0000, 8);
        wr(32'h2000_0000, 31);
        chk_flag(busy, 1'b0);
        chk_flag(write_latch_flag, 1'b1);
        {bp_hi, bp_lo, bp_tb} = 3'h6;
        repeat (3) @(negedge mclk);
        stat(s);
        chk_data({8'h00, s}, 16'h000E);
        wr(32'h5200_0000, 32);
        chk_flag(busy, 1'b0);
        {bp_hi, bp_lo, bp_tb} = 3'h3;
        wr(32'h0600_0000, 8);
        wr(32'h5200_8000, 32);
        chk_flag(busy, 1'b1);
        stat(s);
        chk_data({8'h00, s}, 16'h0027);
        idle_chk();
        dread(1'b1, 24'h008000, 8'h00, q);
        chk_data(q, 16'hFFFF);
        dread(1'b1, 24'h000000, 8'h00, q);
        chk_data(q, 16'h96FF);
        print_verdict();
    end
endmodule // tb
